// File: common/agdc_defines.vh
// Constants for the right AGC decay and ADC path configuration bank.
// Assumes an 8-bit register port decoded from the control bus upstream.
`ifndef AGDC_DEFINES_VH
`define AGDC_DEFINES_VH
`define AGDC_OFS_DECAY 8'h6a
`define AGDC_OFS_PATH 8'h6b
`define AGDC_RST_BYTE 8'h00
`define AGDC_DEC_SEL 7
`define AGDC_DEC_BASE_HI 6
`define AGDC_DEC_BASE_LO 5
`define AGDC_DEC_MULT_HI 4
`define AGDC_DEC_MULT_LO 2
`define AGDC_PATH_HPL 7
`define AGDC_PATH_HPR 6
`define AGDC_PATH_MIC_HI 5
`define AGDC_PATH_MIC_LO 4
`define AGDC_PATH_PF 3
`define AGDC_PATH_DET_OFF 2
`define AGDC_PATH_ERR 0
// Path bits that a write may store; bits 1:0 are read-only
`define AGDC_PATH_WR_MASK 8'hfc
// Decay times in ms
`define AGDC_BASE0_MS 16'h0032
`define AGDC_BASE1_MS 16'h0096
`define AGDC_BASE2_MS 16'h00fa
`define AGDC_BASE3_MS 16'h015e
// Caps in ms per codec clock ratio code (ratio*2-2)
`define AGDC_CAP_R1_MS 16'h0fa0
`define AGDC_CAP_R15_MS 16'h15e0
`define AGDC_CAP_R2_MS 16'h1f40
`define AGDC_CAP_R25_MS 16'h2580
`define AGDC_CAP_R3_MS 16'h2bc0
`define AGDC_CAP_R4_MS 16'h3e80
`define AGDC_CAP_R5_MS 16'h4b00
`define AGDC_CAP_R55_MS 16'h5780
`endif

// File: rtl/agdc_config_bank.v
// Register bank: right AGC decay time select and ADC path / bus condition.
// Assumes the control-bus slave presents byte reads and writes on sys_clk_i,
// and that the bus-error event arrives from the same clock domain.
// Legacy decay, clock ratio and DAC power levels come from logic on the
// same clock, so no synchroniser stands in front of them.
// All outputs are flops; configuration outputs lag a write by two edges.
// Notes on behaviour
// - Select bit 0 uses legacy decay time, 1 uses baseline times multiplier.
// - Baseline code picks 50, 150, 250 or 350 ms.
// - Multiplier code scales baseline by two to the power of code.
// - Effective decay is capped by the codec clock ratio, 4 s to 22.4 s.
// - Left high-pass uses programmable coefficients when its select bit is set.
// - Right high-pass uses programmable coefficients when its select bit is set.
// - Two-bit field sets digital or analog microphone per channel.
// - Programmable filter joins ADC output only if set and both DACs off.
// - Detector bit 0 enables bus error detection, 1 disables it.
// - Error status bit reads 1 once a bus error was detected.
// - Reading the path register clears the error status bit.
`timescale 1ns/100ps
`include "agdc_defines.vh"
module agdc_config_bank (
  input wire sys_clk_i,
  input wire srst_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [15:0] legacy_decay_ms_i,
  input wire [3:0] codec_clock_ratio_i,
  input wire dac_l_pwr_i,
  input wire dac_r_pwr_i,
  input wire bus_err_evt_i,
  output reg [7:0] reg_rdata_o,
  output reg [23:0] decay_ms_o,
  output reg hpf_l_prog_o,
  output reg hpf_r_prog_o,
  output reg mic_l_analog_o,
  output reg mic_r_analog_o,
  output reg prog_filt_adc_o,
  output reg bus_det_en_o,
  output reg bus_err_clr_o
);
  reg [7:0] decay_r;
  reg [7:0] path_r;
  reg err_r;
  reg err_nxt;
  reg pf_nxt;
  reg [7:0] rdata_nxt;
  reg [15:0] base_ms;
  reg [23:0] raw_ms;
  reg [23:0] cap_ms;
  reg [23:0] eff_ms;
  wire wr_decay;
  wire wr_path;
  wire rd_decay;
  wire rd_path;
  wire err_set;
  wire dec_sel;
  wire [1:0] dec_base;
  wire [2:0] dec_mult;
  wire path_hpl;
  wire path_hpr;
  wire path_mic_l;
  wire path_mic_r;
  wire path_pf;
  wire path_det_off;
  wire dacs_down;
  wire [7:0] path_wr_val;

  // Address decode of the two registers
  assign wr_decay = reg_wr_i && (reg_addr_i == `AGDC_OFS_DECAY);
  assign wr_path = reg_wr_i && (reg_addr_i == `AGDC_OFS_PATH);
  assign rd_decay = reg_rd_i && (reg_addr_i == `AGDC_OFS_DECAY);
  assign rd_path = reg_rd_i && (reg_addr_i == `AGDC_OFS_PATH);

  // Decay register field views
  assign dec_sel = decay_r[`AGDC_DEC_SEL];
  assign dec_base = decay_r[`AGDC_DEC_BASE_HI:`AGDC_DEC_BASE_LO];
  assign dec_mult = decay_r[`AGDC_DEC_MULT_HI:`AGDC_DEC_MULT_LO];

  // Path register field views
  assign path_hpl = path_r[`AGDC_PATH_HPL];
  assign path_hpr = path_r[`AGDC_PATH_HPR];
  assign path_mic_l = path_r[`AGDC_PATH_MIC_HI];
  assign path_mic_r = path_r[`AGDC_PATH_MIC_LO];
  assign path_pf = path_r[`AGDC_PATH_PF];
  assign path_det_off = path_r[`AGDC_PATH_DET_OFF];

  // Both DACs powered down
  assign dacs_down = !dac_l_pwr_i && !dac_r_pwr_i;

  assign path_wr_val = reg_wdata_i & `AGDC_PATH_WR_MASK;

  assign err_set = bus_err_evt_i && !path_det_off;

  // Decay register storage
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      decay_r <= `AGDC_RST_BYTE;
    end else if (wr_decay) begin
      decay_r <= reg_wdata_i;
    end
  end

  // Path register storage
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      path_r <= `AGDC_RST_BYTE;
    end else if (wr_path) begin
      path_r <= path_wr_val;
    end
  end

  // Sticky error next state, set wins over read clear
  always @* begin
    err_nxt = err_r;
    if (err_set) begin
      err_nxt = 1'b1;
    end else if (rd_path) begin
      err_nxt = 1'b0;
    end
  end

  // Error status flop
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      err_r <= 1'b0;
    end else begin
      err_r <= err_nxt;
    end
  end

  // Baseline decay lookup
  always @* begin
    case (dec_base)
      2'b00: base_ms = `AGDC_BASE0_MS;
      2'b01: base_ms = `AGDC_BASE1_MS;
      2'b10: base_ms = `AGDC_BASE2_MS;
      default: base_ms = `AGDC_BASE3_MS;
    endcase
  end

  // Cap per ratio code: 0=1, 1=1.5 ... 4 and 5=3, 6 and 7=4, 8=5, 9 and above=5.5
  always @* begin
    case (codec_clock_ratio_i)
      4'h0: cap_ms = {8'h00, `AGDC_CAP_R1_MS};
      4'h1: cap_ms = {8'h00, `AGDC_CAP_R15_MS};
      4'h2: cap_ms = {8'h00, `AGDC_CAP_R2_MS};
      4'h3: cap_ms = {8'h00, `AGDC_CAP_R25_MS};
      4'h4: cap_ms = {8'h00, `AGDC_CAP_R3_MS};
      4'h5: cap_ms = {8'h00, `AGDC_CAP_R3_MS};
      4'h6: cap_ms = {8'h00, `AGDC_CAP_R4_MS};
      4'h7: cap_ms = {8'h00, `AGDC_CAP_R4_MS};
      4'h8: cap_ms = {8'h00, `AGDC_CAP_R5_MS};
      default: cap_ms = {8'h00, `AGDC_CAP_R55_MS};
    endcase
  end

  // Decay source and power-of-two scaling
  always @* begin
    raw_ms = {8'h00, base_ms} << dec_mult;
    if (!dec_sel) begin
      raw_ms = {8'h00, legacy_decay_ms_i};
    end
  end

  // Cap applied to either source
  always @* begin
    if (raw_ms > cap_ms) begin
      eff_ms = cap_ms;
    end else begin
      eff_ms = raw_ms;
    end
  end

  // Programmable filter path gate
  always @* begin
    pf_nxt = 1'b0;
    if (path_pf && dacs_down) begin
      pf_nxt = 1'b1;
    end
  end

  // Read data select, unmapped reads give zero
  always @* begin
    rdata_nxt = `AGDC_RST_BYTE;
    if (rd_decay) begin
      rdata_nxt = decay_r;
    end else if (rd_path) begin
      rdata_nxt = {path_r[7:1], err_r};
    end
  end

  // Read data flop, holds until the next read
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      // Idle read value
      reg_rdata_o <= `AGDC_RST_BYTE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // Effective decay time flop
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      // Zero until the first update
      decay_ms_o <= 24'h00_0000;
    end else begin
      decay_ms_o <= eff_ms;
    end
  end

  // Left coefficient select flop
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      // Default coefficients
      hpf_l_prog_o <= 1'b0;
    end else begin
      hpf_l_prog_o <= path_hpl;
    end
  end

  // Right coefficient select flop
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      // Default coefficients
      hpf_r_prog_o <= 1'b0;
    end else begin
      hpf_r_prog_o <= path_hpr;
    end
  end

  // Left microphone type flop
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      // Digital microphone
      mic_l_analog_o <= 1'b0;
    end else begin
      mic_l_analog_o <= path_mic_l;
    end
  end

  // Right microphone type flop
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      // Digital microphone
      mic_r_analog_o <= 1'b0;
    end else begin
      mic_r_analog_o <= path_mic_r;
    end
  end

  // Programmable filter path flop
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      // High-pass only
      prog_filt_adc_o <= 1'b0;
    end else begin
      prog_filt_adc_o <= pf_nxt;
    end
  end

  // Bus error detector enable flop
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      // Detector on after reset
      bus_det_en_o <= 1'b1;
    end else begin
      bus_det_en_o <= !path_det_off;
    end
  end

  // Bus error clear pulse flop
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      // No clear pending
      bus_err_clr_o <= 1'b0;
    end else begin
      bus_err_clr_o <= err_set;
    end
  end
endmodule

// File: test/agdc_host_model.sv
// Host model: byte read and write cycles on the register port.
// Assumes one clock and one-cycle strobes.
`timescale 1ns/100ps
module agdc_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial {wr_o, rd_o, addr_o, wdata_o} = 18'h0_0000;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d & (a == 8'h6a ? 8'hfc : 8'hfd);
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  // Data taken after the strobe edge lands
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 q = rdata_i;
  endtask
endmodule

// File: test/agdc_chk.sv
// Checker: port relations of the config bank.
// Assumes binding onto agdc_config_bank.
`timescale 1ns/100ps
module agdc_chk (
  input wire sys_clk_i,
  input wire srst_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire dac_l_pwr_i,
  input wire dac_r_pwr_i,
  input wire bus_err_evt_i,
  input wire [7:0] reg_rdata_o,
  input wire hpf_l_prog_o,
  input wire hpf_r_prog_o,
  input wire mic_l_analog_o,
  input wire mic_r_analog_o,
  input wire prog_filt_adc_o,
  input wire bus_det_en_o,
  input wire bus_err_clr_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // Path register strobes
  wire w6b = reg_wr_i && reg_addr_i == 8'h6b;
  wire r6b = reg_rd_i && reg_addr_i == 8'h6b;
  wire e = bus_err_evt_i;
  AST_HPL: assert property (w6b |-> ##2 hpf_l_prog_o == $past(reg_wdata_i[7], 2)) else $error("hpf left");
  AST_HPR: assert property (w6b |-> ##2 hpf_r_prog_o == $past(reg_wdata_i[6], 2)) else $error("hpf right");
  AST_MIC: assert property (w6b |-> ##2 {mic_l_analog_o, mic_r_analog_o} == $past(reg_wdata_i[5:4], 2))
    else $error("mic type");
  AST_PFD: assert property (prog_filt_adc_o |-> !$past(dac_l_pwr_i) && !$past(dac_r_pwr_i)) else $error("pf dac");
  AST_DET: assert property (w6b |-> ##2 bus_det_en_o != $past(reg_wdata_i[2], 2)) else $error("detector");
  AST_CLR: assert property (bus_err_clr_o |-> $past(bus_err_evt_i)) else $error("clear pulse");
  AST_SET: assert property ((bus_err_clr_o && !r6b) ##1 r6b |=> reg_rdata_o[0]) else $error("status set");
  AST_RDC: assert property ((r6b && !e) ##1 !e ##1 (r6b && !e) |=> !reg_rdata_o[0]) else $error("no clear");
  AST_RSV: assert property (r6b |=> !reg_rdata_o[1]) else $error("bit one");
  CV_ERR: cover property (bus_err_clr_o ##1 r6b);
  CV_PF: cover property (prog_filt_adc_o);
  CV_W: cover property (w6b);
endmodule
bind agdc_config_bank agdc_chk u_chk (.*);

// File: test/test_agdc_config_bank.sv
// Testbench: register sequences against the config bank.
// Assumes the host model owns the register strobes.
`timescale 1ns/100ps
module test_agdc_config_bank;
  logic clk = 0, rst = 1, dl, dr, ev, wr, rd, pf, hl, hr, ml, mr, de, ec;
  logic [7:0] a, d, q, v;
  logic [15:0] leg;
  logic [3:0] rat;
  logic [23:0] dm, e;
  // Decay caps per ratio code 0..9 (caps of ratio 1, 1.5, 2, 2.5, 3, 3, 4, 4, 5, 5.5)
  logic [23:0] capv [0:9] = '{24'h00_0fa0, 24'h00_15e0, 24'h00_1f40, 24'h00_2580, 24'h00_2bc0,
    24'h00_2bc0, 24'h00_3e80, 24'h00_3e80, 24'h00_4b00, 24'h00_5780};
  int err_count = 0, n_compared = 0;
  always #5 clk = ~clk;
  agdc_host_model host (.clk_i(clk), .rdata_i(q), .wr_o(wr), .rd_o(rd), .addr_o(a), .wdata_o(d));
  agdc_config_bank uut (.sys_clk_i(clk), .srst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(a),
    .reg_wdata_i(d), .legacy_decay_ms_i(leg), .codec_clock_ratio_i(rat), .dac_l_pwr_i(dl), .dac_r_pwr_i(dr),
    .bus_err_evt_i(ev), .reg_rdata_o(q), .decay_ms_o(dm), .hpf_l_prog_o(hl), .hpf_r_prog_o(hr),
    .mic_l_analog_o(ml), .mic_r_analog_o(mr), .prog_filt_adc_o(pf), .bus_det_en_o(de), .bus_err_clr_o(ec));
  task chk(input logic [23:0] g, input logic [23:0] x);
    n_compared++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %0t got %0h exp %0h", $time, g, x);
    end
  endtask
  task wrap_up;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task sett;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task pulse;
    @(posedge clk);
    ev <= 1;
    @(posedge clk);
    ev <= 0;
  endtask
  initial begin
    #300000;
    err_count++;
    wrap_up;
  end
  // Main sequence
  initial begin
    dl = 1'b0;
    dr = 1'b0;
    ev = 1'b0;
    leg = 16'h0064;
    rat = 4'ha;
    repeat (12) @(posedge clk);
    rst <= 0;
    host.wr(8'h6a, 8'h00); sett; chk(dm, 24'h00_0064);
    for (int b = 0; b < 4; b++) for (int m = 0; m < 8; m++) begin
      host.wr(8'h6a, {1'b1, b[1:0], m[2:0], 2'b00}); sett;
      e = (24'h00_0032 + 24'h00_0064 * b) << m;
      chk(dm, e > 24'h00_5780 ? 24'h00_5780 : e);
    end
    @(posedge clk); rat <= 4'h0;
    host.wr(8'h6a, 8'hff); sett; chk(dm, 24'h00_0fa0);
    for (int r = 1; r < 10; r++) begin
      @(posedge clk); rat <= r[3:0];
      sett; chk(dm, capv[r]);
    end
    host.rd(8'h6a, v); chk(v, 8'hfc);
    host.rd(8'h6c, v); chk(v, 8'h00);
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h6b, k << 4); sett; chk({ml, mr}, k[1:0]);
    end
    host.wr(8'h6b, 8'hff); sett; chk({hl, hr, pf, de}, 4'b1110);
    pulse;
    #1 chk(ec, 1'b0);
    host.rd(8'h6b, v); chk(v, 8'hfc);
    @(posedge clk); dl <= 1; sett; chk(pf, 0);
    host.wr(8'h6b, 8'h28); sett; chk({pf, de}, 2'b01);
    pulse;
    #1 chk(ec, 1'b1);
    host.rd(8'h6b, v); chk(v, 8'h29);
    pulse; sett; host.rd(8'h6b, v); chk(v, 8'h29);
    host.rd(8'h6b, v); chk(v, 8'h28);
    wrap_up;
  end
endmodule
